// *** rtl/interconnect_event_bus.sv ***
// Top of the interconnect event bus with four event counters.
`include "event_bus_consts.svh"
module interconnect_event_bus
    import event_bus_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic secure_count_enable,
    input wire logic debug_count_enable,
    input wire logic [4:0] read_request_fire,
    input wire logic [4:0] read_request_secure,
    input wire logic [9:0] read_class,
    input wire logic [14:0] read_kind,
    input wire logic [4:0] read_tracker_full_stall,
    input wire logic [4:0] read_id_hazard_stall,
    input wire logic [4:0] read_stall_secure,
    input wire logic [4:0] read_last_fire,
    input wire logic [4:0] read_from_snoop,
    input wire logic [4:0] read_data_secure,
    input wire logic [4:0] slave_read_valid,
    input wire logic [4:0] slave_read_ready,
    input wire logic [4:0] write_request_fire,
    input wire logic [4:0] write_request_secure,
    input wire logic [4:0] write_device,
    input wire logic [4:0] write_shareable,
    input wire logic [14:0] write_kind,
    input wire logic [4:0] slave_write_full_stall,
    input wire logic [4:0] write_stall_secure,
    input wire logic [5:0] retry_scheduled,
    input wire logic [2:0] retry_secure,
    input wire logic [2:0] address_hazard_stall,
    input wire logic [2:0] id_hazard_stall,
    input wire logic [2:0] read_barrier_stall,
    input wire logic [2:0] write_barrier_stall,
    input wire logic [2:0] unique_hazard_stall,
    input wire logic [2:0] queue_full_high_stall,
    input wire logic [2:0] queue_low_stall,
    input wire logic [2:0] queue_medium_stall,
    input wire logic [2:0] master_write_full_stall,
    input wire logic [11:0] read_virtual_network_token_wait,
    input wire logic [11:0] write_virtual_network_token_wait,
    input wire logic [2:0] master_stall_secure,
    input wire logic [31:0] event_select,
    input wire logic [3:0] counter_enable,
    input wire logic counter_clear,
    output logic [158:0] event_vector_out,
    output logic [127:0] event_count
);
    // ----------------------------------------
    // Slave interface groups
    // ----------------------------------------
    // slave groups from bit 0
    genvar s;
    generate
        for (s = 0; s < `NUM_SLAVE; s = s + 1) begin : gen_slave
            slave_port_events u_slave (
                .clk(clk),
                .resetn(resetn),
                .secure_count_enable(secure_count_enable),
                .debug_count_enable(debug_count_enable),
                .read_request_fire(read_request_fire[s]),
                .read_request_secure(read_request_secure[s]),
                .read_class(read_class[2*s +: 2]),
                .read_kind(read_kind[3*s +: 3]),
                .read_tracker_full_stall(read_tracker_full_stall[s]),
                .read_id_hazard_stall(read_id_hazard_stall[s]),
                .read_stall_secure(read_stall_secure[s]),
                .read_last_fire(read_last_fire[s]),
                .read_from_snoop(read_from_snoop[s]),
                .read_data_secure(read_data_secure[s]),
                .slave_read_valid(slave_read_valid[s]),
                .slave_read_ready(slave_read_ready[s]),
                .write_request_fire(write_request_fire[s]),
                .write_request_secure(write_request_secure[s]),
                .write_device(write_device[s]),
                .write_shareable(write_shareable[s]),
                .write_kind(write_kind[3*s +: 3]),
                .write_tracker_full_stall(slave_write_full_stall[s]),
                .write_stall_secure(write_stall_secure[s]),
                .slave_port_events(event_vector_out[`SLAVE_GROUP_W*s +: `SLAVE_GROUP_W])
            );
        end
    endgenerate

    // ----------------------------------------
    // Master interface groups
    // ----------------------------------------
    // master groups from bit 105
    genvar m;
    generate
        for (m = 0; m < `NUM_MASTER; m = m + 1) begin : gen_master
            master_port_events u_master (
                .clk(clk),
                .resetn(resetn),
                .secure_count_enable(secure_count_enable),
                .debug_count_enable(debug_count_enable),
                .retry_scheduled(retry_scheduled[2*m +: 2]),
                .retry_secure(retry_secure[m]),
                .address_hazard_stall(address_hazard_stall[m]),
                .id_hazard_stall(id_hazard_stall[m]),
                .read_barrier_stall(read_barrier_stall[m]),
                .write_barrier_stall(write_barrier_stall[m]),
                .unique_hazard_stall(unique_hazard_stall[m]),
                .queue_full_high_stall(queue_full_high_stall[m]),
                .queue_low_stall(queue_low_stall[m]),
                .queue_medium_stall(queue_medium_stall[m]),
                .write_tracker_full_stall(master_write_full_stall[m]),
                .read_virtual_network_token_wait(read_virtual_network_token_wait[4*m +: 4]),
                .write_virtual_network_token_wait(write_virtual_network_token_wait[4*m +: 4]),
                .stall_secure(master_stall_secure[m]),
                .master_port_events(event_vector_out[`MASTER_BASE + `MASTER_GROUP_W*m +: `MASTER_GROUP_W])
            );
        end
    endgenerate

    // ----------------------------------------
    // Event counters
    // ----------------------------------------
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : gen_counter
            // split code into source and number
            wire [2:0] source = event_select[8*c + `SOURCE_LSB +: 3];
            wire [4:0] number = event_select[8*c +: 5];
            wire is_master = source >= `FIRST_MASTER_SOURCE;
            wire [2:0] master_idx = source - `FIRST_MASTER_SOURCE;
            wire [7:0] slave_bit = 8'(source) * 8'(`SLAVE_GROUP_W) + 8'(number);
            wire [7:0] master_bit = 8'(`MASTER_BASE) + 8'(master_idx) * 8'(`MASTER_GROUP_W) + 8'(number);
            wire in_range = is_master ? (number < 5'(`MASTER_GROUP_W)) : (number < 5'(`SLAVE_GROUP_W));
            wire [7:0] bit_index = is_master ? master_bit : slave_bit;
            wire hit = in_range && event_vector_out[bit_index];
            count_state_type state;
            count_state_type next_state;
            assign next_state = counter_enable[c] ? COUNT_RUN : COUNT_IDLE;
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    state <= COUNT_IDLE;
                end else begin
                    state <= next_state;
                end
            end
            wire [31:0] next_count = event_count[32*c +: 32] + 32'(hit && state == COUNT_RUN);
            always_ff @(posedge clk) begin
                if (!resetn || counter_clear) begin
                    event_count[32*c +: 32] <= 32'h00000000;
                end else begin
                    event_count[32*c +: 32] <= next_count;
                end
            end
        end
    endgenerate
endmodule

// *** rtl/event_bus_consts.svh ***
// Constants for the interconnect performance-event bus.
`ifndef EVENT_BUS_CONSTS_SVH
`define EVENT_BUS_CONSTS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define NUM_SLAVE 5
`define NUM_MASTER 3
`define SLAVE_GROUP_W 21
`define MASTER_GROUP_W 18
`define EVENT_VECTOR_W 159
`define MASTER_BASE 105
`define SOURCE_MSB 7
`define SOURCE_LSB 5
`define NUMBER_MSB 4
`define NUMBER_LSB 0
`define FIRST_MASTER_SOURCE 3'h5
`define COUNTER_W 32

// ----------------------------------------
// Slave event numbers
// ----------------------------------------
`define SEV_RD_ANY 5'h00
`define SEV_RD_DEVICE 5'h01
`define SEV_RD_NORMAL 5'h02
`define SEV_RD_SHARE 5'h03
`define SEV_RD_MAINT 5'h04
`define SEV_RD_MBAR 5'h05
`define SEV_RD_SBAR 5'h06
`define SEV_RD_DVM 5'h07
`define SEV_RD_DVM_SYNC 5'h08
`define SEV_RD_FULL 5'h09
`define SEV_SNOOP_DATA 5'h0A
`define SEV_RDATA_STALL 5'h0B
`define SEV_WR_ANY 5'h0C
`define SEV_WR_DEVICE 5'h0D
`define SEV_WR_NORMAL 5'h0E
`define SEV_WR_BACK 5'h0F
`define SEV_WR_UNIQUE 5'h10
`define SEV_WR_LINE 5'h11
`define SEV_WR_EVICT 5'h12
`define SEV_WR_FULL 5'h13
`define SEV_RD_IDHAZ 5'h14

// ----------------------------------------
// Master event numbers
// ----------------------------------------
`define MEV_RETRY 5'h00
`define MEV_ADDR_HAZ 5'h01
`define MEV_ID_HAZ 5'h02
`define MEV_Q_HIGH 5'h03
`define MEV_RD_BAR 5'h04
`define MEV_WR_BAR 5'h05
`define MEV_WR_FULL 5'h06
`define MEV_Q_LOW 5'h07
`define MEV_Q_MED 5'h08
`define MEV_RD_TOKEN 5'h09
`define MEV_WR_TOKEN 5'h0D
`define MEV_UNIQUE_HAZ 5'h11

`endif

// *** rtl/event_bus_pkg.sv ***
// Types shared by the performance-event logic.
package event_bus_pkg;
    typedef enum logic [1:0] {
        READ_CLASS_NORMAL = 2'h0,
        READ_CLASS_SHARE = 2'h1,
        READ_CLASS_DEVICE = 2'h2,
        READ_CLASS_OTHER = 2'h3
    } read_class_type;
    typedef enum logic [2:0] {
        READ_KIND_PLAIN = 3'h0,
        READ_KIND_MAINT = 3'h1,
        READ_KIND_MBAR = 3'h2,
        READ_KIND_SBAR = 3'h3,
        READ_KIND_DVM = 3'h4,
        READ_KIND_DVM_SYNC = 3'h5
    } read_kind_type;
    typedef enum logic [2:0] {
        WRITE_KIND_PLAIN = 3'h0,
        WRITE_KIND_BACK = 3'h1,
        WRITE_KIND_UNIQUE = 3'h2,
        WRITE_KIND_LINE = 3'h3,
        WRITE_KIND_EVICT = 3'h4,
        WRITE_KIND_BARRIER = 3'h5
    } write_kind_type;
    typedef enum logic [1:0] {
        COUNT_IDLE = 2'b01,
        COUNT_RUN = 2'b10
    } count_state_type;
endpackage

// *** rtl/slave_port_events.sv ***
// Event decode for one slave interface.
`include "event_bus_consts.svh"
module slave_port_events
    import event_bus_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic secure_count_enable,
    input wire logic debug_count_enable,
    input wire logic read_request_fire,
    input wire logic read_request_secure,
    input wire logic [1:0] read_class,
    input wire logic [2:0] read_kind,
    input wire logic read_tracker_full_stall,
    input wire logic read_id_hazard_stall,
    input wire logic read_stall_secure,
    input wire logic read_last_fire,
    input wire logic read_from_snoop,
    input wire logic read_data_secure,
    input wire logic slave_read_valid,
    input wire logic slave_read_ready,
    input wire logic write_request_fire,
    input wire logic write_request_secure,
    input wire logic write_device,
    input wire logic write_shareable,
    input wire logic [2:0] write_kind,
    input wire logic write_tracker_full_stall,
    input wire logic write_stall_secure,
    output logic [20:0] slave_port_events
);
    // ----------------------------------------
    // Qualification
    // ----------------------------------------
    // secure gating
    wire rd_ok = debug_count_enable && (!read_request_secure || secure_count_enable);
    wire rs_ok = debug_count_enable && (!read_stall_secure || secure_count_enable);
    wire rdata_ok = debug_count_enable && (!read_data_secure || secure_count_enable);
    wire wr_ok = debug_count_enable && (!write_request_secure || secure_count_enable);
    wire ws_ok = debug_count_enable && (!write_stall_secure || secure_count_enable);
    wire rd_fire = read_request_fire && rd_ok;
    wire wr_fire = write_request_fire && wr_ok;
    wire rd_plain = read_kind == READ_KIND_PLAIN;
    wire wr_bar = write_kind == WRITE_KIND_BARRIER;

    // ----------------------------------------
    // Event decode
    // ----------------------------------------
    logic [20:0] next_events;
    always_comb begin
        next_events = 21'h000000;
        next_events[`SEV_RD_ANY] = rd_fire;
        next_events[`SEV_RD_DEVICE] = rd_fire && read_class == READ_CLASS_DEVICE;
        next_events[`SEV_RD_NORMAL] = rd_fire && rd_plain && read_class == READ_CLASS_NORMAL;
        next_events[`SEV_RD_SHARE] = rd_fire && rd_plain && read_class == READ_CLASS_SHARE;
        next_events[`SEV_RD_MAINT] = rd_fire && read_kind == READ_KIND_MAINT;
        next_events[`SEV_RD_MBAR] = rd_fire && read_kind == READ_KIND_MBAR;
        next_events[`SEV_RD_SBAR] = rd_fire && read_kind == READ_KIND_SBAR;
        next_events[`SEV_RD_DVM] = rd_fire && read_kind == READ_KIND_DVM;
        next_events[`SEV_RD_DVM_SYNC] = rd_fire && read_kind == READ_KIND_DVM_SYNC;
        next_events[`SEV_RD_FULL] = read_tracker_full_stall && rs_ok;
        next_events[`SEV_WR_FULL] = write_tracker_full_stall && ws_ok;
        next_events[`SEV_RD_IDHAZ] = read_id_hazard_stall && rs_ok;
        next_events[`SEV_SNOOP_DATA] = read_last_fire && read_from_snoop && rdata_ok;
        next_events[`SEV_RDATA_STALL] = slave_read_valid && !slave_read_ready && rdata_ok;
        next_events[`SEV_WR_ANY] = wr_fire;
        next_events[`SEV_WR_DEVICE] = wr_fire && write_device;
        next_events[`SEV_WR_NORMAL] = wr_fire && !write_device && !write_shareable && !wr_bar;
        next_events[`SEV_WR_BACK] = wr_fire && write_shareable && write_kind == WRITE_KIND_BACK;
        next_events[`SEV_WR_UNIQUE] = wr_fire && write_kind == WRITE_KIND_UNIQUE;
        next_events[`SEV_WR_LINE] = wr_fire && write_kind == WRITE_KIND_LINE;
        next_events[`SEV_WR_EVICT] = wr_fire && write_kind == WRITE_KIND_EVICT;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            slave_port_events <= 21'h000000;
        end else begin
            slave_port_events <= next_events;
        end
    end
endmodule

// *** rtl/master_port_events.sv ***
// Event decode for one master interface.
`include "event_bus_consts.svh"
module master_port_events
    import event_bus_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic secure_count_enable,
    input wire logic debug_count_enable,
    input wire logic [1:0] retry_scheduled,
    input wire logic retry_secure,
    input wire logic address_hazard_stall,
    input wire logic id_hazard_stall,
    input wire logic read_barrier_stall,
    input wire logic write_barrier_stall,
    input wire logic unique_hazard_stall,
    input wire logic queue_full_high_stall,
    input wire logic queue_low_stall,
    input wire logic queue_medium_stall,
    input wire logic write_tracker_full_stall,
    input wire logic [3:0] read_virtual_network_token_wait,
    input wire logic [3:0] write_virtual_network_token_wait,
    input wire logic stall_secure,
    output logic [17:0] master_port_events
);
    // ----------------------------------------
    // Qualification
    // ----------------------------------------
    // secure gating
    wire sec_ok = debug_count_enable && (!stall_secure || secure_count_enable);
    wire retry_ok = debug_count_enable && (!retry_secure || secure_count_enable);

    logic [17:0] next_events;
    always_comb begin
        next_events = 18'h00000;
        next_events[`MEV_RETRY] = (|retry_scheduled) && retry_ok;
        next_events[`MEV_ADDR_HAZ] = address_hazard_stall && sec_ok;
        next_events[`MEV_ID_HAZ] = id_hazard_stall && debug_count_enable;
        next_events[`MEV_RD_BAR] = read_barrier_stall && sec_ok;
        next_events[`MEV_WR_BAR] = write_barrier_stall && sec_ok;
        next_events[`MEV_UNIQUE_HAZ] = unique_hazard_stall && sec_ok;
        next_events[`MEV_Q_HIGH] = queue_full_high_stall && sec_ok;
        next_events[`MEV_Q_LOW] = queue_low_stall && sec_ok;
        next_events[`MEV_Q_MED] = queue_medium_stall && sec_ok;
        next_events[`MEV_WR_FULL] = write_tracker_full_stall && sec_ok;
        next_events[`MEV_RD_TOKEN +: 4] = read_virtual_network_token_wait & {4{debug_count_enable}};
        next_events[`MEV_WR_TOKEN +: 4] = write_virtual_network_token_wait & {4{debug_count_enable}};
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            master_port_events <= 18'h00000;
        end else begin
            master_port_events <= next_events;
        end
    end
endmodule

// *** dv/event_bus_chk.sv ***
// Port assertions for the interconnect event bus top.
module event_bus_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic secure_count_enable,
    input wire logic debug_count_enable,
    input wire logic [4:0] read_request_fire,
    input wire logic [4:0] read_request_secure,
    input wire logic [4:0] read_id_hazard_stall,
    input wire logic [4:0] read_stall_secure,
    input wire logic [4:0] read_data_secure,
    input wire logic [4:0] slave_read_valid,
    input wire logic [4:0] slave_read_ready,
    input wire logic [5:0] retry_scheduled,
    input wire logic [2:0] retry_secure,
    input wire logic [2:0] id_hazard_stall,
    input wire logic [2:0] unique_hazard_stall,
    input wire logic [2:0] master_stall_secure,
    input wire logic [11:0] write_virtual_network_token_wait,
    input wire logic counter_clear,
    input wire logic [158:0] event_vector_out,
    input wire logic [127:0] event_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    logic rst_q;
    // Masks the edge after reset, whose pulses were cleared.
    always_ff @(posedge clk) rst_q <= !resetn;
    default disable iff (!resetn || rst_q);
    property p_debug_gate; !debug_count_enable |=> event_vector_out == '0; endproperty
    a_debug_gate: assert property (p_debug_gate) else $error("vector busy while export disabled");
    property p_pulse; debug_count_enable && !read_request_secure[0] |=> event_vector_out[0] == $past(read_request_fire[0]); endproperty
    a_pulse: assert property (p_pulse) else $error("read pulse on slave 0 wrong");
    property p_sec_drop; read_request_fire[1] && read_request_secure[1] && !secure_count_enable |=> !event_vector_out[21]; endproperty
    a_sec_drop: assert property (p_sec_drop) else $error("secure read exported");
    property p_sec_pass; debug_count_enable && secure_count_enable && read_request_fire[1] |=> event_vector_out[21]; endproperty
    a_sec_pass: assert property (p_sec_pass) else $error("secure read missing");
    property p_id_free; debug_count_enable && id_hazard_stall[2] |=> event_vector_out[143]; endproperty
    a_id_free: assert property (p_id_free) else $error("master ID stall missing");
    property p_token; debug_count_enable && write_virtual_network_token_wait[11] |=> event_vector_out[157]; endproperty
    a_token: assert property (p_token) else $error("token wait missing");
    property p_retry; debug_count_enable && !retry_secure[1] && |retry_scheduled[3:2] |=> event_vector_out[123]; endproperty
    a_retry: assert property (p_retry) else $error("retry event missing");
    property p_id_haz; debug_count_enable && read_id_hazard_stall[4] && !read_stall_secure[4] |=> event_vector_out[104]; endproperty
    a_id_haz: assert property (p_id_haz) else $error("slave 4 ID stall missing");
    property p_rstall; debug_count_enable && slave_read_valid[3] && !slave_read_ready[3] && !read_data_secure[3] |=> event_vector_out[74]; endproperty
    a_rstall: assert property (p_rstall) else $error("read data stall missing");
    property p_uniq; debug_count_enable && unique_hazard_stall[0] && !master_stall_secure[0] |=> event_vector_out[122]; endproperty
    a_uniq: assert property (p_uniq) else $error("unique hazard missing");
    property p_clear; counter_clear |=> event_count == '0; endproperty
    a_clear: assert property (p_clear) else $error("counters not cleared");
    c_secure: cover property (secure_count_enable && debug_count_enable && read_request_fire[1] && read_request_secure[1]);
    c_clear: cover property (counter_clear && event_count != '0);
    c_retry: cover property (retry_scheduled[3:2] == 2'h3 && debug_count_enable);
endmodule

bind interconnect_event_bus event_bus_chk i_chk (.*);

// *** dv/event_count_model.sv ***
// Counter-side model that tallies selected pulses of the event vector.
module event_count_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [158:0] event_vector_out,
    input wire logic [31:0] event_select,
    input wire logic [3:0] counter_enable,
    input wire logic counter_clear,
    output logic [127:0] model_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] running;
    function automatic logic hit(input logic [7:0] code);
        int src;
        int num;
        src = int'(code[7:5]);
        num = int'(code[4:0]);
        if (src < 5) return num <= 20 ? event_vector_out[21 * src + num] : 1'b0;
        return num <= 17 ? event_vector_out[105 + 18 * (src - 5) + num] : 1'b0;
    endfunction
    always_ff @(posedge clk) begin
        if (!resetn) begin
            running <= '0;
            model_count <= '0;
        end else begin
            running <= counter_enable;
            for (int c = 0; c < 4; c++) begin
                if (counter_clear) model_count[32*c+:32] <= '0;
                else if (running[c] && hit(event_select[8*c+:8])) model_count[32*c+:32] <= model_count[32*c+:32] + 32'h1;
            end
        end
    end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the interconnect event bus.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic secure_count_enable, debug_count_enable, counter_clear;
    logic [4:0] read_request_fire, read_request_secure, read_tracker_full_stall, read_id_hazard_stall;
    logic [4:0] read_stall_secure, read_last_fire, read_from_snoop, read_data_secure, slave_read_valid;
    logic [4:0] slave_read_ready, write_request_fire, write_request_secure, write_device, write_shareable;
    logic [4:0] slave_write_full_stall, write_stall_secure;
    logic [9:0] read_class;
    logic [14:0] read_kind, write_kind;
    logic [5:0] retry_scheduled;
    logic [2:0] retry_secure, address_hazard_stall, id_hazard_stall, read_barrier_stall, write_barrier_stall;
    logic [2:0] unique_hazard_stall, queue_full_high_stall, queue_low_stall, queue_medium_stall;
    logic [2:0] master_write_full_stall, master_stall_secure;
    logic [11:0] read_virtual_network_token_wait, write_virtual_network_token_wait;
    logic [31:0] event_select;
    logic [3:0] counter_enable;
    logic [158:0] event_vector_out, exp_vec;
    logic [127:0] event_count, model_count;
    logic [159:0] r;
    int fail_count = 0, checks_done = 0, cycles = 0;

    interconnect_event_bus i_dut (.*);
    event_count_model i_model (.*);

    always #4 clk = ~clk;

    task automatic results();
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check_vec(input logic [158:0] got, input logic [158:0] want);
        checks_done++;
        if (got !== want) begin
            fail_count++;
            $display("FAIL %0t vector %h expected %h", $time, got, want);
        end
    endtask
    task automatic check_count(input logic [127:0] got, input logic [127:0] want);
        checks_done++;
        if (got !== want) begin
            fail_count++;
            $display("FAIL %0t counts %h expected %h", $time, got, want);
        end
    endtask
    task automatic set_flat(input logic [132:0] f);
        {read_request_fire, read_request_secure, read_tracker_full_stall, read_id_hazard_stall, read_stall_secure,
         read_last_fire, read_from_snoop, read_data_secure, slave_read_valid, slave_read_ready, write_request_fire,
         write_request_secure, slave_write_full_stall, write_stall_secure, retry_scheduled, retry_secure,
         address_hazard_stall, id_hazard_stall, read_barrier_stall, write_barrier_stall, unique_hazard_stall,
         queue_full_high_stall, queue_low_stall, queue_medium_stall, master_write_full_stall, master_stall_secure,
         read_virtual_network_token_wait, write_virtual_network_token_wait} <= f;
    endtask
    // Non-plain reads use class 3; shareable-only write kinds are shareable.
    task automatic drive_random();
        logic [14:0] rk, wk;
        logic [9:0] rc;
        logic [4:0] dv, sh;
        r = {$urandom, $urandom, $urandom, $urandom, $urandom};
        for (int s = 0; s < 5; s++) begin
            rk[3*s+:3] = 3'($urandom % 6);
            wk[3*s+:3] = 3'($urandom % 6);
            rc[2*s+:2] = rk[3*s+:3] == 3'h0 ? 2'($urandom) : 2'h3;
            dv[s] = wk[3*s+:3] inside {[3'h1:3'h4]} ? 1'b0 : r[133+s];
            sh[s] = wk[3*s+:3] inside {[3'h1:3'h4]} ? 1'b1 : !dv[s] && r[138+s];
        end
        set_flat(r[132:0]);
        read_kind <= rk;
        read_class <= rc;
        write_kind <= wk;
        write_device <= dv;
        write_shareable <= sh;
    endtask
    function automatic logic ok(input logic sec);
        return debug_count_enable && (!sec || secure_count_enable);
    endfunction
    function automatic logic [158:0] expect_vec();
        logic [158:0] v;
        logic rf, wf, g;
        logic [1:0] rc;
        logic [2:0] rk, wk;
        int b;
        v = '0;
        for (int s = 0; s < 5; s++) begin
            b = 21 * s;
            rc = read_class[2*s+:2];
            rk = read_kind[3*s+:3];
            wk = write_kind[3*s+:3];
            rf = read_request_fire[s] && ok(read_request_secure[s]);
            wf = write_request_fire[s] && ok(write_request_secure[s]);
            v[b] = rf;
            v[b+1] = rf && rc == 2'h2;
            v[b+2] = rf && rc == 2'h0 && rk == 3'h0;
            v[b+3] = rf && rc == 2'h1 && rk == 3'h0;
            for (int k = 1; k < 6; k++) v[b+3+k] = rf && rk == k;
            v[b+9] = read_tracker_full_stall[s] && ok(read_stall_secure[s]);
            v[b+10] = read_last_fire[s] && read_from_snoop[s] && ok(read_data_secure[s]);
            v[b+11] = slave_read_valid[s] && !slave_read_ready[s] && ok(read_data_secure[s]);
            v[b+12] = wf;
            v[b+13] = wf && write_device[s];
            v[b+14] = wf && !write_device[s] && !write_shareable[s] && wk != 3'h5;
            v[b+15] = wf && write_shareable[s] && wk == 3'h1;
            for (int k = 2; k < 5; k++) v[b+14+k] = wf && wk == k;
            v[b+19] = slave_write_full_stall[s] && ok(write_stall_secure[s]);
            v[b+20] = read_id_hazard_stall[s] && ok(read_stall_secure[s]);
        end
        for (int m = 0; m < 3; m++) begin
            b = 105 + 18 * m;
            g = ok(master_stall_secure[m]);
            v[b] = |retry_scheduled[2*m+:2] && ok(retry_secure[m]);
            v[b+1] = address_hazard_stall[m] && g;
            v[b+2] = id_hazard_stall[m] && debug_count_enable;
            v[b+3] = queue_full_high_stall[m] && g;
            v[b+4] = read_barrier_stall[m] && g;
            v[b+5] = write_barrier_stall[m] && g;
            v[b+6] = master_write_full_stall[m] && g;
            v[b+7] = queue_low_stall[m] && g;
            v[b+8] = queue_medium_stall[m] && g;
            for (int n = 0; n < 4; n++) begin
                v[b+9+n] = read_virtual_network_token_wait[4*m+n] && debug_count_enable;
                v[b+13+n] = write_virtual_network_token_wait[4*m+n] && debug_count_enable;
            end
            v[b+17] = unique_hazard_stall[m] && g;
        end
        return resetn ? v : '0;
    endfunction

    always @(posedge clk) exp_vec <= expect_vec();
    always @(negedge clk) begin
        check_vec(event_vector_out, exp_vec);
        check_count(event_count, model_count);
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            $display("FAIL %0t run did not finish", $time);
            results();
        end
    end

    initial begin
        r[31:0] = $urandom(32'hE4B67430);
        secure_count_enable = 1'b0;
        debug_count_enable = 1'b1;
        counter_clear = 1'b0;
        counter_enable = 4'hF;
        event_select = 32'hA015_03F1;
        read_class = '0;
        read_kind = '0;
        write_kind = '0;
        write_device = '0;
        write_shareable = '0;
        set_flat('0);
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        // Both retry halves at once give one event per cycle.
        retry_scheduled <= 6'h3F;
        repeat (4) @(posedge clk);
        for (int p = 0; p < 8; p++) begin
            debug_count_enable <= (p % 4 != 1);
            secure_count_enable <= p[1];
            if (p > 0) event_select <= $urandom;
            if (p > 0) counter_enable <= 4'($urandom);
            counter_clear <= (p == 3);
            if (p == 5) resetn <= 1'b0;
            repeat (300) begin
                @(posedge clk);
                counter_clear <= 1'b0;
                resetn <= 1'b1;
                drive_random();
            end
        end
        results();
    end
endmodule
